// File: swwc_ctrl.sv
/*
 * chip mode sequencing, transceiver mode, window watchdog and local wake-up logic.
 * assumes a host link of chip select, clock and data, sampled on rising clock edges,
 * and raw wake and supply levels straight from pins.
 */
module swwc_ctrl #(
	parameter int TICK_CYCLES = swwc_pkg::US_CYCLES,
	parameter int N_WAKE = 3
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic [N_WAKE-1:0] wake_in,
	input wire logic can_supply_ok,
	output logic host_rst_n,
	output logic main_reg_en,
	output logic can_reg_en,
	output logic v3_en,
	output swwc_pkg::swwc_can_t can_mode,
	output logic [N_WAKE-1:0] wake_status,
	output swwc_pkg::swwc_mode_t chip_mode,
	output logic wd_open
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SW = N_WAKE + 3;
	// link domain: frame shifter on the host clock
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [6:0] shift, next_shift;
	logic [7:0] frame_word, next_frame_word;
	logic frame_tgl, next_frame_tgl;

	always_comb begin
		next_bit_cnt = bit_cnt + 3'h1;
		next_shift = {shift[5:0], spi_mosi};
		next_frame_word = frame_word;
		next_frame_tgl = frame_tgl;
		if (bit_cnt == 3'h7) begin
			next_frame_word = {shift, spi_mosi};
			next_frame_tgl = !frame_tgl;
		end
	end

	// chip select high restarts the bit count; no clock edge comes between frames
	always_ff @(posedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n)
			bit_cnt <= 3'h0;
		else
			bit_cnt <= next_bit_cnt;
	end

	always_ff @(posedge spi_sck or negedge nrst) begin
		if (!nrst) begin
			shift <= 7'h00;
			frame_word <= 8'h00;
			frame_tgl <= 1'b0;
		end else begin
			shift <= next_shift;
			frame_word <= next_frame_word;
			frame_tgl <= next_frame_tgl;
		end
	end

	// synchronisers reset to idle levels, so no false frame end follows reset
	logic [SW-1:0] s1, s2, s3, next_s1, next_s2, next_s3;
	logic cs_rise, tgl_chg, can_ok;
	logic [N_WAKE-1:0] wake_lvl;

	always_comb begin
		next_s1 = {spi_cs_n, frame_tgl, can_supply_ok, wake_in};
		next_s2 = s1;
		next_s3 = s2;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1 <= {1'b1, {(SW-1){1'b0}}};
			s2 <= {1'b1, {(SW-1){1'b0}}};
			s3 <= {1'b1, {(SW-1){1'b0}}};
		end else begin
			s1 <= next_s1;
			s2 <= next_s2;
			s3 <= next_s3;
		end
	end

	assign cs_rise = s2[SW-1] && !s3[SW-1];
	assign tgl_chg = s2[SW-2] ^ s3[SW-2];
	assign can_ok = s2[N_WAKE];
	assign wake_lvl = s2[N_WAKE-1:0];

	// microsecond tick; shrinking TICK_CYCLES shortens every long time at once
	logic [15:0] tick_cnt, next_tick_cnt;
	logic us_tick, next_us_tick;

	always_comb begin
		next_us_tick = (tick_cnt == 16'(TICK_CYCLES - 1));
		next_tick_cnt = next_us_tick ? 16'h0000 : tick_cnt + 16'h0001;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tick_cnt <= 16'h0000;
			us_tick <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			us_tick <= next_us_tick;
		end
	end

	// main state
	swwc_pkg::swwc_mode_t next_chip_mode;
	swwc_pkg::swwc_can_t next_can_mode;
	swwc_pkg::swwc_v3cfg_t v3cfg, next_v3cfg;
	swwc_pkg::swwc_cmd_t cmd;
	logic [swwc_pkg::TMR_W-1:0] tmr, next_tmr, wd_half, next_wd_half;
	logic [2:0] wd_sel, next_wd_sel, cyc_sel, next_cyc_sel;
	logic [7:0] pend_word, next_pend_word;
	logic pend, next_pend;
	logic next_host_rst_n, next_main_reg_en, next_can_reg_en, next_v3_en, next_wd_open;
	logic [N_WAKE-1:0] next_wake_status, wake_hit, clr_mask;
	logic cmd_go, cfg_ok, cfg_wr, perm_en, cyc_act, smp_pulse;

	assign cmd_go = cs_rise && pend;
	assign cmd = swwc_pkg::swwc_cmd_t'(pend_word);
	assign cfg_ok = (chip_mode == swwc_pkg::MD_NORMAL) || (chip_mode == swwc_pkg::MD_STANDBY);
	assign cfg_wr = cmd_go && cfg_ok && (cmd.addr == swwc_pkg::CMD_WAKE);
	assign perm_en = (cfg_ok && (!v3cfg.on_switched || v3_en))
		|| (chip_mode == swwc_pkg::MD_SLEEP && !v3cfg.on_switched);
	assign cyc_act = (chip_mode == swwc_pkg::MD_SLEEP) && v3cfg.cyclic_en;
	assign smp_pulse = cyc_act && us_tick && (tmr == swwc_pkg::SAMPLE_TICKS);
	assign clr_mask = (cmd_go && cfg_ok && cmd.addr == swwc_pkg::CMD_CLR)
		? cmd.data[N_WAKE-1:0] : '0;
	assign wd_half = swwc_pkg::wd_period_us(wd_sel) >> 1;

	always_comb begin
		next_chip_mode = chip_mode;
		next_tmr = us_tick ? tmr + 24'h000001 : tmr;
		next_wd_sel = wd_sel;
		next_cyc_sel = cyc_sel;
		next_v3cfg = v3cfg;
		next_can_mode = can_mode;
		next_pend = pend;
		next_pend_word = pend_word;
		// a new frame landing with the commit keeps its pending mark
		if (cmd_go)
			next_pend = 1'b0;
		if (tgl_chg) begin
			next_pend = 1'b1;
			next_pend_word = frame_word;
		end
		unique case (chip_mode)
			swwc_pkg::MD_RESET: begin
				if (tmr >= swwc_pkg::RESET_TICKS) begin
					next_chip_mode = swwc_pkg::MD_NREQ;
					next_tmr = '0;
				end
			end
			swwc_pkg::MD_NREQ: begin
				if (cmd_go && cmd.addr == swwc_pkg::CMD_WD) begin
					next_wd_sel = cmd.data[2:0];
					next_chip_mode = swwc_pkg::MD_NORMAL;
					next_tmr = '0;
				end else if (cmd_go && cmd.addr == swwc_pkg::CMD_MODE
					&& cmd.data[1:0] == swwc_pkg::GO_EMERG) begin
					next_chip_mode = swwc_pkg::MD_EMERG;
				end else if (tmr >= swwc_pkg::NREQ_TICKS) begin
					next_chip_mode = swwc_pkg::MD_SLEEP;
					next_tmr = '0;
				end
			end
			swwc_pkg::MD_NORMAL, swwc_pkg::MD_STANDBY: begin
				if (cmd_go && cmd.addr == swwc_pkg::CMD_WD) begin
					if (tmr < wd_half) begin
						next_chip_mode = swwc_pkg::MD_RESET;
						next_tmr = '0;
					end else begin
						next_tmr = '0;
						next_wd_sel = cmd.data[2:0];
					end
				end else if (tmr >= swwc_pkg::wd_period_us(wd_sel)) begin
					next_chip_mode = swwc_pkg::MD_RESET;
					next_tmr = '0;
				end else if (cmd_go && cmd.addr == swwc_pkg::CMD_MODE) begin
					next_tmr = '0;
					unique case (cmd.data[1:0])
						swwc_pkg::GO_NORMAL: next_chip_mode = swwc_pkg::MD_NORMAL;
						swwc_pkg::GO_STANDBY: next_chip_mode = swwc_pkg::MD_STANDBY;
						swwc_pkg::GO_SLEEP: next_chip_mode = swwc_pkg::MD_SLEEP;
						swwc_pkg::GO_EMERG: next_chip_mode = swwc_pkg::MD_EMERG;
					endcase
				end
				// a validated wake-up while running only flags
				if (cmd_go && cmd.addr == swwc_pkg::CMD_CYC)
					next_cyc_sel = cmd.data[2:0];
				if (cmd_go && cmd.addr == swwc_pkg::CMD_V3)
					next_v3cfg = swwc_pkg::swwc_v3cfg_t'(cmd.data[3:0]);
				if (cmd_go && cmd.addr == swwc_pkg::CMD_CAN && chip_mode == swwc_pkg::MD_NORMAL
					&& cmd.data[1:0] != 2'h3)
					next_can_mode = swwc_pkg::swwc_can_t'(cmd.data[1:0]);
			end
			swwc_pkg::MD_SLEEP: begin
				if (|wake_hit) begin
					next_chip_mode = swwc_pkg::MD_RESET;
					next_tmr = '0;
				end else if (cyc_act) begin
					if (tmr >= swwc_pkg::cyc_period_us(cyc_sel))
						next_tmr = '0;
				end else if (v3cfg.forced_en) begin
					if (tmr >= swwc_pkg::cyc_period_us(cyc_sel)) begin
						next_chip_mode = swwc_pkg::MD_RESET;
						next_tmr = '0;
					end
				end
			end
			swwc_pkg::MD_EMERG: begin
				next_tmr = '0;
			end
		endcase
		if (next_chip_mode != swwc_pkg::MD_NORMAL || !can_ok)
			next_can_mode = swwc_pkg::CAN_STANDBY;
		next_wake_status = (wake_status & ~clr_mask) | wake_hit;
		next_host_rst_n = !(next_chip_mode inside {swwc_pkg::MD_RESET, swwc_pkg::MD_SLEEP,
			swwc_pkg::MD_EMERG});
		next_main_reg_en = !(next_chip_mode inside {swwc_pkg::MD_SLEEP, swwc_pkg::MD_EMERG});
		next_can_reg_en = (next_chip_mode == swwc_pkg::MD_NORMAL);
		next_v3_en = 1'b0;
		if (next_chip_mode inside {swwc_pkg::MD_NORMAL, swwc_pkg::MD_STANDBY})
			next_v3_en = next_v3cfg.v3_on;
		else if (next_chip_mode == swwc_pkg::MD_SLEEP && next_v3cfg.cyclic_en)
			next_v3_en = (next_tmr < swwc_pkg::V3_ON_TICKS);
		next_wd_half = swwc_pkg::wd_period_us(next_wd_sel) >> 1;
		next_wd_open = (next_chip_mode inside {swwc_pkg::MD_NORMAL, swwc_pkg::MD_STANDBY})
			&& (next_tmr >= next_wd_half);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			chip_mode <= swwc_pkg::MD_RESET;
			tmr <= '0;
			wd_sel <= swwc_pkg::WD_SEL_RST;
			cyc_sel <= swwc_pkg::CYC_SEL_RST;
			v3cfg <= '0;
			can_mode <= swwc_pkg::CAN_STANDBY;
			pend <= 1'b0;
			pend_word <= 8'h00;
			wake_status <= '0;
			host_rst_n <= 1'b0;
			main_reg_en <= 1'b1;
			can_reg_en <= 1'b0;
			v3_en <= 1'b0;
			wd_open <= 1'b0;
		end else begin
			chip_mode <= next_chip_mode;
			tmr <= next_tmr;
			wd_sel <= next_wd_sel;
			cyc_sel <= next_cyc_sel;
			v3cfg <= next_v3cfg;
			can_mode <= next_can_mode;
			pend <= next_pend;
			pend_word <= next_pend_word;
			wake_status <= next_wake_status;
			host_rst_n <= next_host_rst_n;
			main_reg_en <= next_main_reg_en;
			can_reg_en <= next_can_reg_en;
			v3_en <= next_v3_en;
			wd_open <= next_wd_open;
		end
	end

	for (genvar i = 0; i < N_WAKE; i++) begin : g_wake
		swwc_pkg::swwc_wopt_t opt, next_opt;
		logic flt, next_flt, refl, next_refl, perm_hit, cyc_hit;
		logic [swwc_pkg::FLT_W-1:0] fcnt, next_fcnt;
		logic [3:0] hist, next_hist;
		logic [2:0] nsmp, next_nsmp;

		always_comb begin
			next_opt = opt;
			next_flt = flt;
			next_refl = refl;
			next_fcnt = '0;
			next_hist = hist;
			next_nsmp = nsmp;
			if (wake_lvl[i] != flt) begin
				if (fcnt == swwc_pkg::FILTER_LAST)
					next_flt = wake_lvl[i];
				else
					next_fcnt = fcnt + 12'h001;
			end
			if (perm_en)
				next_refl = flt;
			if (cfg_wr && cmd.data[4:3] == 2'(i)) begin
				next_opt = swwc_pkg::swwc_wopt_t'(cmd.data[2:0]);
				next_refl = flt;
			end
			if (!cyc_act) begin
				next_hist = 4'h0;
				next_nsmp = 3'h0;
			end else if (smp_pulse) begin
				next_hist = {hist[2:0], wake_lvl[i]};
				if (nsmp != 3'h4)
					next_nsmp = nsmp + 3'h1;
			end
		end

		always_comb begin
			perm_hit = 1'b0;
			cyc_hit = 1'b0;
			unique case (opt)
				swwc_pkg::WO_NONE: ;
				swwc_pkg::WO_HIGH: begin
					perm_hit = flt;
					cyc_hit = hist[0];
				end
				swwc_pkg::WO_LOW: begin
					perm_hit = !flt;
					cyc_hit = !hist[0];
				end
				swwc_pkg::WO_RISE: begin
					perm_hit = flt && !refl;
					cyc_hit = (hist == 4'h3);
				end
				swwc_pkg::WO_FALL: begin
					perm_hit = !flt && refl;
					cyc_hit = (hist == 4'hc);
				end
				swwc_pkg::WO_CHANGE, swwc_pkg::WO_BOTH: begin
					perm_hit = flt != refl;
					cyc_hit = (hist == 4'h3) || (hist == 4'hc);
				end
				default: ;
			endcase
			perm_hit = perm_hit && perm_en;
			cyc_hit = cyc_hit && cyc_act && (nsmp == 3'h4);
		end

		assign wake_hit[i] = perm_hit || cyc_hit;

		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				opt <= swwc_pkg::WO_NONE;
				flt <= 1'b0;
				refl <= 1'b0;
				fcnt <= '0;
				hist <= 4'h0;
				nsmp <= 3'h0;
			end else begin
				opt <= next_opt;
				flt <= next_flt;
				refl <= next_refl;
				fcnt <= next_fcnt;
				hist <= next_hist;
				nsmp <= next_nsmp;
			end
		end
	end : g_wake

endmodule : swwc_ctrl

// File: swwc_ctrl_assertions.sv
/*
 * port checks of the watchdog and wake-up control block.
 * assumes all checks run on ref_clk and pause while nrst is low.
 */
module swwc_ctrl_assertions #(
	parameter int TICK_CYCLES = 125,
	parameter int N_WAKE = 3
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic [N_WAKE-1:0] wake_in,
	input wire logic can_supply_ok,
	input wire logic host_rst_n,
	input wire logic main_reg_en,
	input wire logic can_reg_en,
	input wire logic v3_en,
	input wire swwc_pkg::swwc_can_t can_mode,
	input wire logic [N_WAKE-1:0] wake_status,
	input var swwc_pkg::swwc_mode_t chip_mode,
	input wire logic wd_open
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	// cycles spent in normal request; two spare ticks cover tick alignment
	localparam int NREQ_LIMIT = (swwc_pkg::NREQ_TIMEOUT_MS * 1000 + 2) * TICK_CYCLES;
	int nreq_cnt;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			nreq_cnt <= 0;
		else if (chip_mode == swwc_pkg::MD_NREQ)
			nreq_cnt <= nreq_cnt + 1;
		else
			nreq_cnt <= 0;
	end
	a_nreq_bound: assert property (
		chip_mode == swwc_pkg::MD_NREQ |-> nreq_cnt <= NREQ_LIMIT)
		else $error("normal request held past its timeout");
	// leaving sleep, and the transceiver leaving bus standby
	sequence s_sleep_leave;
		chip_mode == swwc_pkg::MD_SLEEP ##1 chip_mode != swwc_pkg::MD_SLEEP;
	endsequence
	sequence s_can_up;
		can_mode == swwc_pkg::CAN_STANDBY ##1 can_mode != swwc_pkg::CAN_STANDBY;
	endsequence
	a_can_outside: assert property (
		chip_mode != swwc_pkg::MD_NORMAL |-> can_mode == swwc_pkg::CAN_STANDBY)
		else $error("transceiver on outside normal");
	a_supply_drop: assert property (
		$fell(can_supply_ok) |-> ##[1:5] can_mode == swwc_pkg::CAN_STANDBY)
		else $error("transceiver kept after supply loss");
	a_can_by_frame: assert property (
		s_can_up |-> spi_cs_n && $past(spi_cs_n, 3))
		else $error("transceiver left standby without a frame");
	a_can_supply_off: assert property (
		!can_reg_en |-> can_mode == swwc_pkg::CAN_STANDBY)
		else $error("transceiver on with its supply off");
	a_wd_in_modes: assert property (
		wd_open |-> chip_mode inside {swwc_pkg::MD_NORMAL, swwc_pkg::MD_STANDBY})
		else $error("watchdog window outside normal or standby");
	a_no_wd_reset: assert property (
		$past(chip_mode) inside {swwc_pkg::MD_NREQ, swwc_pkg::MD_EMERG}
		|-> chip_mode != swwc_pkg::MD_RESET) else $error("reset from an unwatched mode");
	a_reset_host: assert property (
		chip_mode == swwc_pkg::MD_RESET |-> !host_rst_n && main_reg_en)
		else $error("host reset not driven in reset mode");
	a_sleep_off: assert property (
		chip_mode == swwc_pkg::MD_SLEEP |-> !main_reg_en && !can_reg_en && !host_rst_n)
		else $error("supplies on in sleep");
	a_sleep_exit: assert property (
		s_sleep_leave |-> chip_mode == swwc_pkg::MD_RESET ##1 !host_rst_n)
		else $error("sleep left without host reset");
endmodule : swwc_ctrl_assertions

bind swwc_ctrl swwc_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES), .N_WAKE(N_WAKE)) u_chk (
	.ref_clk(ref_clk), .nrst(nrst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
	.spi_mosi(spi_mosi), .wake_in(wake_in), .can_supply_ok(can_supply_ok),
	.host_rst_n(host_rst_n), .main_reg_en(main_reg_en), .can_reg_en(can_reg_en),
	.v3_en(v3_en), .can_mode(can_mode), .wake_status(wake_status),
	.chip_mode(chip_mode), .wd_open(wd_open));

// File: swwc_ctrl_test.sv
/*
 * self-checking bench: host model sends frames, bench drives wake and supply levels.
 * assumes one ref_clk cycle per microsecond tick so the long timers stay short.
 */
module swwc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] wake_in = 3'h0;
	logic can_supply_ok = 1'h1;
	logic spi_sck, spi_cs_n, spi_mosi, host_rst_n, main_reg_en, can_reg_en, v3_en, wd_open;
	logic [2:0] wake_status;
	swwc_pkg::swwc_can_t can_mode;
	swwc_pkg::swwc_mode_t chip_mode;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int n;
	always #4 ref_clk = ~ref_clk;
	swwc_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
	swwc_ctrl #(.TICK_CYCLES(1)) uut (.ref_clk(ref_clk), .nrst(nrst), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wake_in(wake_in),
		.can_supply_ok(can_supply_ok), .host_rst_n(host_rst_n), .main_reg_en(main_reg_en),
		.can_reg_en(can_reg_en), .v3_en(v3_en), .can_mode(can_mode),
		.wake_status(wake_status), .chip_mode(chip_mode), .wd_open(wd_open));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one frame, then time for it to commit
	task automatic snd(input logic [2:0] a, input logic [4:0] d);
		host.send(swwc_pkg::swwc_cmd_t'({a, d}));
		repeat (8) @(posedge ref_clk);
	endtask : snd
	// bounded waits; n holds the cycles spent
	task automatic wm(input swwc_pkg::swwc_mode_t m, input int lim);
		for (n = 0; chip_mode !== m && n < lim; n++) @(posedge ref_clk);
		chk(chip_mode, m);
	endtask : wm
	task automatic wo(input int lim);
		for (n = 0; wd_open !== 1'b1 && n < lim; n++) @(posedge ref_clk);
	endtask : wo
	task automatic wv(input logic lvl, input int lim);
		for (n = 0; v3_en !== lvl && n < lim; n++) @(posedge ref_clk);
	endtask : wv
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results
	// hang guard, sized above the roughly 101k cycles the tests need
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 115000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		chk(host_rst_n, 1'b0);
		wm(swwc_pkg::MD_NREQ, 1100);
		snd(swwc_pkg::CMD_CAN, 5'h1);
		chk(can_mode, swwc_pkg::CAN_STANDBY);
		snd(swwc_pkg::CMD_WD, 5'h0);
		wm(swwc_pkg::MD_NORMAL, 20);
		wo(2600);
		chk(n > 2470 && n < 2510, 1'b1);
		snd(swwc_pkg::CMD_WD, 5'h1);
		chk(wd_open, 1'b0);
		wo(5100);
		chk(n > 4980 && n < 5006, 1'b1);
		$display("test watchdog window done");
		// every transceiver mode, then a supply dip inside the open window
		for (int i = 1; i <= 3; i++) begin
			snd(swwc_pkg::CMD_CAN, 5'(i % 3));
			chk(can_mode, i % 3);
		end
		snd(swwc_pkg::CMD_CAN, 5'h1);
		can_supply_ok <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk(can_mode, swwc_pkg::CAN_STANDBY);
		can_supply_ok <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk(can_mode, swwc_pkg::CAN_STANDBY);
		snd(swwc_pkg::CMD_CAN, 5'h2);
		chk(can_mode, swwc_pkg::CAN_RECEIVE_ONLY_MODE);
		$display("test transceiver done");
		// an early trigger, then a missing one in standby
		snd(swwc_pkg::CMD_WD, 5'h7);
		chk(chip_mode, swwc_pkg::MD_NORMAL);
		snd(swwc_pkg::CMD_WD, 5'h7);
		chk(host_rst_n, 1'b0);
		wm(swwc_pkg::MD_NREQ, 1100);
		snd(swwc_pkg::CMD_WD, 5'h0);
		chk(can_reg_en, 1'b1);
		snd(swwc_pkg::CMD_MODE, {3'h0, swwc_pkg::GO_STANDBY});
		chk(chip_mode, swwc_pkg::MD_STANDBY);
		chk(can_reg_en, 1'b0);
		snd(swwc_pkg::CMD_MODE, {3'h0, swwc_pkg::GO_NORMAL});
		chk(chip_mode, swwc_pkg::MD_NORMAL);
		snd(swwc_pkg::CMD_MODE, {3'h0, swwc_pkg::GO_STANDBY});
		chk(chip_mode, swwc_pkg::MD_STANDBY);
		wm(swwc_pkg::MD_RESET, 5100);
		chk(n > 4900, 1'b1);
		wm(swwc_pkg::MD_NREQ, 1100);
		$display("test watchdog faults done");
		// options: input 0 high, 1 none then low, 2 change
		snd(swwc_pkg::CMD_WD, 5'h7);
		snd(swwc_pkg::CMD_WAKE, 5'h01);
		snd(swwc_pkg::CMD_WAKE, 5'h08);
		snd(swwc_pkg::CMD_WAKE, 5'h13);
		wake_in <= 3'h7;
		repeat (2000) @(posedge ref_clk);
		wake_in <= 3'h0;
		repeat (20) @(posedge ref_clk);
		chk(wake_status, 3'h0);
		wake_in <= 3'h7;
		repeat (3000) @(posedge ref_clk);
		chk(wake_status, 3'h5);
		snd(swwc_pkg::CMD_WAKE, 5'h0a);
		wake_in <= 3'h0;
		repeat (3000) @(posedge ref_clk);
		chk(wake_status, 3'h7);
		snd(swwc_pkg::CMD_WAKE, 5'h08);
		snd(swwc_pkg::CMD_CLR, 5'h07);
		chk(wake_status, 3'h0);
		snd(swwc_pkg::CMD_V3, 5'h08);
		wake_in <= 3'h1;
		repeat (3000) @(posedge ref_clk);
		chk(wake_status, 3'h0);
		snd(swwc_pkg::CMD_V3, 5'h09);
		chk(v3_en, 1'b1);
		repeat (3000) @(posedge ref_clk);
		chk(wake_status, 3'h1);
		wake_in <= 3'h0;
		$display("test wake options done");
		// sleep with both cyclic sensing and forced wake-up enabled
		snd(swwc_pkg::CMD_CYC, 5'h0);
		snd(swwc_pkg::CMD_V3, 5'h0e);
		snd(swwc_pkg::CMD_MODE, {3'h0, swwc_pkg::GO_SLEEP});
		wv(1'b0, 500);
		wv(1'b1, 32000);
		chk(n > 31580 && n < 31620, 1'b1);
		chk(chip_mode, swwc_pkg::MD_SLEEP);
		wv(1'b0, 500);
		chk(n > 395 && n < 405, 1'b1);
		// second reset, then forced wake-up alone
		nrst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		wm(swwc_pkg::MD_NREQ, 1100);
		snd(swwc_pkg::CMD_WD, 5'h7);
		snd(swwc_pkg::CMD_V3, 5'h04);
		snd(swwc_pkg::CMD_MODE, {3'h0, swwc_pkg::GO_SLEEP});
		wm(swwc_pkg::MD_RESET, 33000);
		chk(n > 31900 && n < 32010, 1'b1);
		chk(main_reg_en, 1'b1);
		wm(swwc_pkg::MD_NREQ, 1100);
		$display("test sleep timing done");
		// local wake-up from sleep
		snd(swwc_pkg::CMD_WD, 5'h7);
		snd(swwc_pkg::CMD_WAKE, 5'h04);
		snd(swwc_pkg::CMD_V3, 5'h00);
		snd(swwc_pkg::CMD_MODE, {3'h0, swwc_pkg::GO_SLEEP});
		wake_in <= 3'h1;
		wm(swwc_pkg::MD_RESET, 3000);
		wm(swwc_pkg::MD_NREQ, 1100);
		chk(wake_status[0], 1'b1);
		snd(swwc_pkg::CMD_MODE, {3'h0, swwc_pkg::GO_EMERG});
		chk(chip_mode, swwc_pkg::MD_EMERG);
		chk(main_reg_en, 1'b0);
		chk(host_rst_n, 1'b0);
		$display("test local wake done");
		results();
	end
endmodule : swwc_ctrl_test

// File: swwc_host.sv
/*
 * host model: sends 8-bit command frames on the link, msb first.
 * assumes the link clock runs only inside frames, 12 ns period.
 */
module swwc_host (
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle link: select high, clock low
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// frames as the caller orders them, triggers included
	task automatic send(input swwc_pkg::swwc_cmd_t w);
		logic [7:0] b;
		b = w;
		#2 spi_cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			spi_mosi = b[i];
			#6 spi_sck = 1'b1;
			#6 spi_sck = 1'b0;
		end
		// select rises well after the last clock so the word is pending
		#60 spi_cs_n = 1'b1;
		spi_mosi = ~b[0]; // released line shows no stale bit
		#100;
	endtask : send
endmodule : swwc_host

// File: swwc_pkg.sv
/*
 * shared constants, timing tables and types of the watchdog and wake-up control block.
 * assumes a 125 MHz reference clock and an 8-bit command frame on the host link.
 */
package swwc_pkg;
	timeunit 1ns;
	timeprecision 1ps;

	// reference clock and derived cycle counts
	localparam int CLK_PERIOD_NS = 8;
	localparam int US_CYCLES = (1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_US = 20;
	localparam int FILTER_CYCLES = (FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLT_W = 12;
	localparam logic [FLT_W-1:0] FILTER_LAST = FLT_W'(FILTER_CYCLES - 1);

	// times in microseconds, counted on the microsecond tick
	localparam int TMR_W = 24;
	localparam int RESET_US = 1000;
	localparam int NREQ_TIMEOUT_MS = 75;
	localparam int V3_ON_US = 400;
	localparam int SAMPLE_US = 300;
	localparam int CYC_BASE_US = 32000;
	localparam logic [TMR_W-1:0] RESET_TICKS = TMR_W'(RESET_US);
	localparam logic [TMR_W-1:0] NREQ_TICKS = TMR_W'(NREQ_TIMEOUT_MS * 1000);
	localparam logic [TMR_W-1:0] V3_ON_TICKS = TMR_W'(V3_ON_US);
	localparam logic [TMR_W-1:0] SAMPLE_TICKS = TMR_W'(SAMPLE_US);

	// command addresses, frame bits [7:5]
	localparam logic [2:0] CMD_MODE = 3'h0;
	localparam logic [2:0] CMD_WD = 3'h1;
	localparam logic [2:0] CMD_CAN = 3'h2;
	localparam logic [2:0] CMD_CYC = 3'h3;
	localparam logic [2:0] CMD_V3 = 3'h4;
	localparam logic [2:0] CMD_WAKE = 3'h5;
	localparam logic [2:0] CMD_CLR = 3'h6;

	// mode command codes, data [1:0]
	localparam logic [1:0] GO_NORMAL = 2'h0;
	localparam logic [1:0] GO_STANDBY = 2'h1;
	localparam logic [1:0] GO_SLEEP = 2'h2;
	localparam logic [1:0] GO_EMERG = 2'h3;

	// reset values of the configuration
	localparam logic [2:0] WD_SEL_RST = 3'h0;
	localparam logic [2:0] CYC_SEL_RST = 3'h0;

	typedef enum {MD_RESET, MD_NREQ, MD_NORMAL, MD_STANDBY, MD_SLEEP, MD_EMERG} swwc_mode_t;
	typedef enum logic [1:0] {CAN_STANDBY, CAN_TRANSMIT_RECEIVE_MODE, CAN_RECEIVE_ONLY_MODE} swwc_can_t;
	typedef enum logic [2:0] {WO_NONE, WO_HIGH, WO_LOW, WO_CHANGE, WO_RISE, WO_FALL, WO_BOTH}
		swwc_wopt_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [4:0] data;
	} swwc_cmd_t;

	// switched output control, data [3:0]
	typedef struct packed {
		logic on_switched;
		logic forced_en;
		logic cyclic_en;
		logic v3_on;
	} swwc_v3cfg_t;

	function automatic logic [TMR_W-1:0] wd_period_us(input logic [2:0] sel);
		int p;
		unique case (sel)
			3'h0: p = 5000;
			3'h1: p = 10000;
			3'h2: p = 20000;
			3'h3: p = 33000;
			3'h4: p = 50000;
			3'h5: p = 75000;
			3'h6: p = 100000;
			3'h7: p = 200000;
		endcase
		return TMR_W'(p);
	endfunction : wd_period_us

	// doubling series, the last step jumps by four
	function automatic logic [TMR_W-1:0] cyc_period_us(input logic [2:0] sel);
		int sh;
		sh = (sel == 3'h7) ? 8 : int'(sel);
		return TMR_W'(CYC_BASE_US << sh);
	endfunction : cyc_period_us

endpackage : swwc_pkg
